// ===== common/prs_defines.vh
// Constants of the resource power sequencer.
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH
`define PRS_NUM_RES        8
`define PRS_NUM_CLKREQ     4
`define PRS_TIMER_W        8
`define PRS_MIN_RESET      8'h00
`define PRS_ADDR_MIN       12'h000
`define PRS_ADDR_TIMEREQ   12'h004
`define PRS_ADDR_STATE     12'h008
`define PRS_ADDR_PENDING   12'h00C
`define PRS_ADDR_CTRL      12'h010
`define PRS_ADDR_STATUS    12'h014
`define PRS_ADDR_DELAY     12'h040
`define PRS_ADDR_DEP       12'h060
`define PRS_ADDR_MAP       12'h080
`define PRS_CTRL_SAVE      0
`define PRS_CTRL_WAKE_TMR  1
`define PRS_REG_CORE       0
`define PRS_REG_LOW_NOISE  1
`define PRS_REG_SWITCHING  2
`define PRS_CLK_PLL        3
`define PRS_CLK_XTAL       4
`define PRS_CORE_POWER     5
`define PRS_LP_TICK_NS     30518
`define PRS_CLK_NS         10
`define PRS_TICK_CYCLES    (`PRS_LP_TICK_NS / `PRS_CLK_NS)
`endif

// ===== design/prs_sequencer.v
// Resource power sequencer with dependency table, delay timers and APB registers.
// Behaviour
// - Requests: core clocks, minimum mask, timers.
// - Clock requests map to resource sets.
// - Each resource has one of four states.
// - Timer zero when stable, nonzero when moving.
// - Load on or off delay at start.
// - Timers count low power ticks to zero.
// - Zero delay switches immediately.
// - Required set uses dependency table each tick.
// - Timer reaching zero clears pending, toggles state.
// - Compare required set with current status.
// - Disable only unrequested, dependent-free enabled resource.
// - Enable only requested resource with dependencies on.
// - Regulator-on input powers up, releases reset.
// - Regulators all off when input low.
// - Core regulators follow baseband demand.
// - Programmable delays timed by low power clock.
// - Doze stops main clocks, tick stays.
// - Save core state before deep sleep.
// - Restore core state on wake event.
// - Power-down: all regulators off until re-enabled.
// - Input low holds wireless section in reset.
// - Power-on after shutdown equals fresh power-up.
`timescale 1ns/10ps
`include "prs_defines.vh"
module prs_sequencer #(
  parameter NR          = `PRS_NUM_RES,
  parameter NC          = `PRS_NUM_CLKREQ,
  parameter TW          = `PRS_TIMER_W,
  parameter TICK_CYCLES = `PRS_TICK_CYCLES
) (
  // Clock and reset.
  input  wire          clock,
  input  wire          reset_n,
  // APB slave.
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // Pins and core requests.
  input  wire          regulator_on_request,
  input  wire          low_power_clock,
  input  wire [NC-1:0] core_clock_request,
  input  wire          external_wake,
  input  wire          host_resume,
  // Resource and control outputs.
  output reg  [NR-1:0] resource_enable,
  output reg           wireless_reset_n,
  output reg           retention_save,
  output reg           retention_restore
);
  // ************************************************************
  // Declarations.
  // ************************************************************
  reg  [2:0]      lp_sync;
  reg             lp_state;
  reg  [2:0]      reg_on_sync;
  reg             reg_on;
  reg  [NR-1:0]   minimum_resource_mask;
  reg  [NR-1:0]   resource_on_flag;
  reg  [NR-1:0]   transition_pending_flag;
  reg  [TW-1:0]   timer      [0:NR-1];
  reg  [TW-1:0]   time_on    [0:NR-1];
  reg  [TW-1:0]   time_off   [0:NR-1];
  reg  [NR-1:0]   dep        [0:NR-1];
  reg  [NR-1:0]   clk_map    [0:NC-1];
  reg  [15:0]     req_timer;
  reg  [NR-1:0]   req_timer_mask;
  reg  [1:0]      ctrl;
  reg             saved;
  reg  [NR-1:0]   need;
  reg  [NR-1:0]   req;
  reg  [NR-1:0]   dependents_on;
  reg  [NR-1:0]   deps_ok;
  reg  [31:0]     rdata;
  reg             hit;
  reg  [2:0]      ext_sync;
  reg             ext_wake;
  reg  [2:0]      host_sync;
  reg             host_wake;
  integer         q;
  integer         r;
  wire            tick;
  wire            access;
  integer         i;
  integer         j;

  // Sets a bit when any dependency closure member needs it.
  function [NR-1:0] prs_closure;
    input [NR-1:0] seed;
    reg   [NR-1:0] acc;
    integer        k;
    integer        m;
    begin
      acc = seed;
      for (k = 0; k < NR; k = k + 1) begin
        for (m = 0; m < NR; m = m + 1) begin
          if (acc[m]) begin
            acc = acc | dep[m];
          end
        end
      end
      prs_closure = acc;
    end
  endfunction

  // Matches an address against one word slot of a register table.
  function prs_slot;
    input [11:0] addr;
    input [11:0] base;
    input integer idx;
    begin
      prs_slot = (addr == base + {idx[9:0], 2'b00});
    end
  endfunction

  // ************************************************************
  // Input synchronisers and tick detection.
  // ************************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lp_sync     <= 3'h0;
      lp_state    <= 1'b0;
      reg_on_sync <= 3'h0;
      reg_on      <= 1'b0;
    end else begin
      lp_sync     <= {lp_sync[1:0], low_power_clock};
      reg_on_sync <= {reg_on_sync[1:0], regulator_on_request};
      if (lp_sync[1] == lp_sync[2]) begin
        lp_state <= lp_sync[2];
      end
      if (reg_on_sync[1] == reg_on_sync[2]) begin
        reg_on <= reg_on_sync[2];
      end
    end
  end

  assign tick = (lp_sync[1] == lp_sync[2]) && lp_sync[2] && !lp_state;

  // ************************************************************
  // Wake pin synchronisers.
  // ************************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ext_sync  <= 3'h0;
      ext_wake  <= 1'b0;
      host_sync <= 3'h0;
      host_wake <= 1'b0;
    end else begin
      ext_sync  <= {ext_sync[1:0], external_wake};
      host_sync <= {host_sync[1:0], host_resume};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_wake <= ext_sync[2];
      end
      if (host_sync[1] == host_sync[2]) begin
        host_wake <= host_sync[2];
      end
    end
  end

  // ************************************************************
  // Required set and start conditions.
  // ************************************************************
  always @* begin
    req = minimum_resource_mask;
    for (q = 0; q < NC; q = q + 1) begin
      if (core_clock_request[q]) begin
        req = req | clk_map[q];
      end
    end
    if (req_timer != 16'h0000) begin
      req = req | req_timer_mask;
    end
    need = prs_closure(req);
    dependents_on = {NR{1'b0}};
    deps_ok       = {NR{1'b0}};
    for (q = 0; q < NR; q = q + 1) begin
      deps_ok[q] = ((dep[q] & ~(resource_on_flag & ~transition_pending_flag)) == 0);
      for (j = 0; j < NR; j = j + 1) begin
        if (dep[j][q] && (resource_on_flag[j] || transition_pending_flag[j])) begin
          dependents_on[q] = 1'b1;
        end
      end
    end
  end

  assign access = psel && penable;

  // ************************************************************
  // Sequencer state and register writes.
  // ************************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      minimum_resource_mask   <= `PRS_MIN_RESET;
      resource_on_flag        <= {NR{1'b0}};
      transition_pending_flag <= {NR{1'b0}};
      req_timer               <= 16'h0000;
      req_timer_mask          <= {NR{1'b0}};
      ctrl                    <= 2'h0;
      saved                   <= 1'b0;
      retention_save          <= 1'b0;
      retention_restore       <= 1'b0;
      for (i = 0; i < NR; i = i + 1) begin
        timer[i]    <= {TW{1'b0}};
        time_on[i]  <= {TW{1'b0}};
        time_off[i] <= {TW{1'b0}};
        dep[i]      <= {NR{1'b0}};
      end
      for (i = 0; i < NC; i = i + 1) begin
        clk_map[i] <= {NR{1'b0}};
      end
    end else if (!reg_on) begin
      minimum_resource_mask   <= `PRS_MIN_RESET;
      resource_on_flag        <= {NR{1'b0}};
      transition_pending_flag <= {NR{1'b0}};
      req_timer               <= 16'h0000;
      ctrl                    <= 2'h0;
      saved                   <= 1'b0;
      retention_save          <= 1'b0;
      retention_restore       <= 1'b0;
      req_timer_mask          <= {NR{1'b0}};
      for (i = 0; i < NR; i = i + 1) begin
        timer[i]    <= {TW{1'b0}};
        time_on[i]  <= {TW{1'b0}};
        time_off[i] <= {TW{1'b0}};
        dep[i]      <= {NR{1'b0}};
      end
      for (i = 0; i < NC; i = i + 1) begin
        clk_map[i] <= {NR{1'b0}};
      end
    end else begin
      retention_save    <= 1'b0;
      retention_restore <= 1'b0;
      if (access && pwrite) begin
        case (paddr)
          `PRS_ADDR_MIN:     minimum_resource_mask <= pwdata[NR-1:0];
          `PRS_ADDR_TIMEREQ: begin
            req_timer      <= pwdata[15:0];
            req_timer_mask <= pwdata[16+NR-1:16];
          end
          `PRS_ADDR_CTRL:    ctrl <= pwdata[1:0];
          default: begin
            for (i = 0; i < NR; i = i + 1) begin
              if (prs_slot(paddr, `PRS_ADDR_DELAY, i)) begin
                time_on[i]  <= pwdata[TW-1:0];
                time_off[i] <= pwdata[16+TW-1:16];
              end
              if (prs_slot(paddr, `PRS_ADDR_DEP, i)) begin
                dep[i] <= pwdata[NR-1:0];
              end
            end
            for (i = 0; i < NC; i = i + 1) begin
              if (prs_slot(paddr, `PRS_ADDR_MAP, i)) begin
                clk_map[i] <= pwdata[NR-1:0];
              end
            end
          end
        endcase
      end
      if (ctrl[`PRS_CTRL_SAVE] && !saved && !need[`PRS_CORE_POWER]
          && resource_on_flag[`PRS_CORE_POWER] && !transition_pending_flag[`PRS_CORE_POWER]) begin
        retention_save <= 1'b1;
        saved          <= 1'b1;
      end
      if (saved && (ext_wake || host_wake || (tick && req_timer == 16'h0001))) begin
        ctrl[`PRS_CTRL_SAVE] <= 1'b0;
        saved                <= 1'b0;
        retention_restore    <= 1'b1;
      end
      if (tick) begin
        if (req_timer != 16'h0000) begin
          req_timer <= req_timer - 16'h0001;
        end
        for (i = 0; i < NR; i = i + 1) begin
          if (transition_pending_flag[i]) begin
            if (timer[i] == {{(TW-1){1'b0}}, 1'b1}) begin
              transition_pending_flag[i] <= 1'b0;
              resource_on_flag[i]        <= ~resource_on_flag[i];
            end
            timer[i] <= timer[i] - {{(TW-1){1'b0}}, 1'b1};
          end else if (!resource_on_flag[i] && need[i] && deps_ok[i]
                       && !(saved && i == `PRS_CORE_POWER)) begin
            if (time_on[i] == {TW{1'b0}}) begin
              resource_on_flag[i] <= 1'b1;
            end else begin
              timer[i]                   <= time_on[i];
              transition_pending_flag[i] <= 1'b1;
            end
          end else if (resource_on_flag[i] && !need[i] && !dependents_on[i]
                       && !(retention_save == 1'b0 && ctrl[`PRS_CTRL_SAVE] && !saved
                            && i == `PRS_CORE_POWER)) begin
            if (time_off[i] == {TW{1'b0}}) begin
              resource_on_flag[i] <= 1'b0;
            end else begin
              timer[i]                   <= time_off[i];
              transition_pending_flag[i] <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      resource_enable  <= {NR{1'b0}};
      wireless_reset_n <= 1'b0;
    end else begin
      resource_enable  <= reg_on ? (resource_on_flag | transition_pending_flag) : {NR{1'b0}};
      wireless_reset_n <= reg_on;
    end
  end

  // ************************************************************
  // APB read path.
  // ************************************************************
  always @* begin
    rdata = 32'h00000000;
    hit   = 1'b1;
    case (paddr)
      `PRS_ADDR_MIN:     rdata[NR-1:0] = minimum_resource_mask;
      `PRS_ADDR_TIMEREQ: rdata = {{(16-NR){1'b0}}, req_timer_mask, req_timer};
      `PRS_ADDR_STATE:   rdata[NR-1:0] = resource_on_flag;
      `PRS_ADDR_PENDING: rdata[NR-1:0] = transition_pending_flag;
      `PRS_ADDR_CTRL:    rdata[1:0] = ctrl;
      `PRS_ADDR_STATUS:  rdata[1:0] = {saved, reg_on};
      default: begin
        hit = 1'b0;
        for (r = 0; r < NR; r = r + 1) begin
          if (prs_slot(paddr, `PRS_ADDR_DELAY, r)) begin
            rdata = {{(16-TW){1'b0}}, time_off[r], {(16-TW){1'b0}}, time_on[r]};
            hit   = 1'b1;
          end
          if (prs_slot(paddr, `PRS_ADDR_DEP, r)) begin
            rdata[NR-1:0] = dep[r];
            hit           = 1'b1;
          end
        end
        for (r = 0; r < NC; r = r + 1) begin
          if (prs_slot(paddr, `PRS_ADDR_MAP, r)) begin
            rdata[NR-1:0] = clk_map[r];
            hit           = 1'b1;
          end
        end
      end
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= (psel && !penable && !pwrite) ? rdata : 32'h00000000;
    end
  end
endmodule // prs_sequencer

// ===== bench/prs_lp_partner.sv
// Host regulator pin and low-power oscillator model.
`timescale 1ns/10ps
module prs_lp_partner (
  // Clock and commands.
  input  wire logic clock,
  input  wire logic step,
  input  wire logic power_up,
  // Pins.
  output logic      low_power_clock,
  output logic      regulator_on_request
);
  logic [2:0] hold;
  initial hold = 3'h0;
  assign low_power_clock      = (hold != 3'h0);
  assign regulator_on_request = power_up;
  // The oscillator gives one pulse per step command.
  always @(posedge clock) begin
    if (step)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
endmodule // prs_lp_partner

// ===== bench/prs_sequencer_assertions.sv
// Concurrent checks on the sequencer ports.
`timescale 1ns/10ps
module prs_sequencer_assertions #(
  parameter NR = 8
) (
  // Clock and reset.
  input wire logic          clock,
  input wire logic          reset_n,
  // Watched signals.
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          regulator_on_request,
  input wire logic          low_power_clock,
  input wire logic [NR-1:0] resource_enable,
  input wire logic          wireless_reset_n,
  input wire logic          retention_save,
  input wire logic          retention_restore
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [3:0] lp_age;
  logic       lp_q;
  // Counts cycles since the last low-power clock rise.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lp_age <= 4'h0;
      lp_q   <= 1'b0;
    end else begin
      lp_q <= low_power_clock;
      if (low_power_clock && !lp_q)
        lp_age <= 4'h0;
      else if (lp_age != 4'hF)
        lp_age <= lp_age + 4'h1;
    end
  end
  AST_REG_OFF: assert property (!regulator_on_request [*8] |->
    (resource_enable == '0) && !wireless_reset_n) else $error("regulators on while pin low");
  AST_RST_FREE: assert property (regulator_on_request [*8] |-> wireless_reset_n)
    else $error("wireless reset held while pin high");
  AST_TICK_ONLY: assert property ($changed(resource_enable) && regulator_on_request
    |-> lp_age < 4'hC) else $error("resource change without tick");
  AST_PREADY: assert property ($rose(penable) && psel |-> pready)
    else $error("no answer in first access cycle");
  AST_PREADY_ONE: assert property (pready |=> !pready) else $error("pready too long");
  AST_PREADY_CAUSE: assert property (pready |-> psel && penable) else $error("stray pready");
  AST_ERR: assert property (pslverr |-> pready) else $error("stray error");
  AST_SAVE: assert property (retention_save |=> !retention_save)
    else $error("save pulse too long");
  AST_RESTORE: assert property (retention_restore |=> !retention_restore)
    else $error("restore pulse too long");
  COV_SAVE: cover property (retention_save);
  COV_WAKE: cover property (retention_restore);
  COV_ERR: cover property (pslverr);
endmodule // prs_sequencer_assertions
bind prs_sequencer prs_sequencer_assertions #(.NR(NR)) i_chk (.clock(clock),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .regulator_on_request(regulator_on_request), .low_power_clock(low_power_clock),
  .resource_enable(resource_enable), .wireless_reset_n(wireless_reset_n),
  .retention_save(retention_save), .retention_restore(retention_restore));

// ===== bench/tb.sv
// Self-checking bench of the sequencer.
`timescale 1ns/10ps
`include "prs_defines.vh"
module tb;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic step = 0, power_up = 0, external_wake = 0, host_resume = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, low_power_clock, regulator_on_request;
  logic [3:0] core_clock_request = 0;
  logic [7:0] resource_enable;
  logic wireless_reset_n, retention_save, retention_restore;
  int n_mismatch = 0, check_count = 0, c, n_save = 0, n_wake = 0;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (retention_save === 1'b1) n_save++;
    if (retention_restore === 1'b1) n_wake++;
  end
  prs_lp_partner i_lp (.clock(clock), .step(step), .power_up(power_up),
    .low_power_clock(low_power_clock), .regulator_on_request(regulator_on_request));
  prs_sequencer i_dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .regulator_on_request(regulator_on_request),
    .low_power_clock(low_power_clock), .core_clock_request(core_clock_request),
    .external_wake(external_wake), .host_resume(host_resume),
    .resource_enable(resource_enable), .wireless_reset_n(wireless_reset_n),
    .retention_save(retention_save), .retention_restore(retention_restore));
  task wrap_up;
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task tick;
    @(posedge clock) step <= 1'b1;
    @(posedge clock) step <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  // Counts ticks after which resource b shows a transition in progress.
  task run(input int n, input int b);
    c = 0;
    repeat (n) begin
      tick();
      apb(1'b0, `PRS_ADDR_PENDING, 32'h0);
      if (rd[b] === 1'b1) c++;
    end
  endtask
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    chk(resource_enable, 32'h0);
    chk(wireless_reset_n, 32'h0);
    apb(1'b0, `PRS_ADDR_MIN, 32'h0);
    chk(rd, `PRS_MIN_RESET);
    apb(1'b0, 12'h100, 32'h0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    power_up <= 1'b1;
    repeat (10) @(posedge clock);
    chk(wireless_reset_n, 32'h1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `PRS_ADDR_DELAY + 12'(4 * i), 32'h0);
      apb(1'b1, `PRS_ADDR_DEP + 12'(4 * i), 32'h0);
    end
    apb(1'b1, `PRS_ADDR_DELAY + 12'h004, 32'h00010002);
    apb(1'b1, `PRS_ADDR_DEP + 12'h004, 32'h1);
    apb(1'b1, `PRS_ADDR_MAP, 32'h10);
    apb(1'b1, `PRS_ADDR_MIN, 32'h2);
    run(6, 1);
    chk(c, 2);
    apb(1'b0, `PRS_ADDR_STATE, 32'h0);
    chk(rd, 32'h3);
    chk(resource_enable, 32'h3);
    apb(1'b1, `PRS_ADDR_MIN, 32'h0);
    run(6, 1);
    chk(c, 1);
    apb(1'b0, `PRS_ADDR_STATE, 32'h0);
    chk(rd, 32'h0);
    core_clock_request <= 4'h1;
    run(3, 4);
    chk(c, 0);
    chk(resource_enable, 32'h10);
    core_clock_request <= 4'h0;
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `PRS_ADDR_MIN, 32'h20);
      tick();
      apb(1'b1, `PRS_ADDR_CTRL, 32'h1);
      apb(1'b1, `PRS_ADDR_MIN, 32'h0);
      if (k == 2) apb(1'b1, `PRS_ADDR_TIMEREQ, 32'h2);
      repeat (3) tick();
      chk(n_save, k + 1);
      external_wake <= (k == 0);
      host_resume <= (k == 1);
      repeat (2) tick();
      chk(n_wake, k + 1);
      external_wake <= 1'b0;
      host_resume <= 1'b0;
    end
    power_up <= 1'b0;
    repeat (10) @(posedge clock);
    chk(resource_enable, 32'h0);
    apb(1'b1, `PRS_ADDR_MIN, 32'hFF);
    power_up <= 1'b1;
    repeat (10) @(posedge clock);
    apb(1'b0, `PRS_ADDR_MIN, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `PRS_ADDR_STATE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `PRS_ADDR_DELAY + 12'h004, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule // tb
